// file: hw/ppc_top.sv
// Command decoder of the parallel programming port.
`timescale 1ns/1ps
// ****************************************************************
// Overview
// ****************************************************************
// The programmer moves one step at a time over a level handshake. It
// raises its request with a mode tag and a word, the decoder answers
// with a registered acknowledge, and the request must drop before the
// acknowledge falls and the next step may start.
// A command step chooses what the following steps mean. A data or
// address step outside its command is answered with the error flag
// and sends the decoder back to idle, so a confused programmer can
// always resynchronise with a fresh command step.
// Once the security bit is set every step is still acknowledged, so
// the programmer never hangs, but nothing is carried out and the
// returned word is zero. Only the erase input or a reset clears the bit.
// Memory writes leave through a small buffer, so a slow memory side
// holds a data step unacknowledged rather than losing a word.
// With the memory side stalled for good such a step waits for good,
// so the programmer has to bound its own wait.
module ppc_top (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Programmer handshake step
  input wire logic step_req,
  input wire logic step_write,
  input wire logic [ppc_pkg::PPC_MODE_W-1:0] step_mode,
  input wire logic [ppc_pkg::PPC_DATA_W-1:0] step_data,
  output logic step_ack,
  output logic [ppc_pkg::PPC_DATA_W-1:0] step_rdata,
  output logic step_err,
  // Nonvolatile bits and erase
  input wire logic [ppc_pkg::PPC_GPB_W-1:0] general_purpose_nonvolatile_bits,
  input wire logic erase_done,
  output logic security_bit,
  // Memory write stream
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [ppc_pkg::PPC_ADDR_W-1:0] mem_addr,
  output logic [ppc_pkg::PPC_DATA_W-1:0] mem_data
);
  import ppc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ppc_cmd_t cmd;
    logic [PPC_ADDR_W-1:0] addr;
    logic [PPC_DATA_W-1:0] rdata;
    logic ack;
    logic err;
    logic secure;
  } ppc_st_t;
  ppc_st_t st_r, st_nxt;

  logic fifo_in_valid, fifo_in_ready;
  logic [PPC_ADDR_W+PPC_DATA_W-1:0] fifo_out;
  logic new_step;
  logic is_cmd_wr, is_addr_lo_wr, is_addr_hi_wr, is_data_wr, is_data_rd;
  logic is_secure_word;
  logic [PPC_ADDR_W-1:0] addr_inc;
  logic [PPC_ADDR_W+PPC_DATA_W-1:0] fifo_in_data;

  // A step is taken once per request; ack stays up until req drops.
  assign new_step = step_req && !st_r.ack;
  assign step_ack = st_r.ack;
  assign step_rdata = st_r.rdata;
  assign step_err = st_r.err;
  assign security_bit = st_r.secure;
  assign mem_addr = fifo_out[PPC_ADDR_W+PPC_DATA_W-1:PPC_DATA_W];
  assign mem_data = fifo_out[PPC_DATA_W-1:0];

  // ****************************************************************
  // Step classification
  // ****************************************************************
  // The mode tag says what the word is, and the direction must match
  // too, so a read step tagged as a command is treated as out of order.
  assign is_cmd_wr = (step_mode == PPC_MODE_COMMAND) && step_write;
  assign is_addr_lo_wr = (step_mode == PPC_MODE_ADDR_LOW) && step_write;
  assign is_addr_hi_wr = (step_mode == PPC_MODE_ADDR_HIGH) && step_write;
  assign is_data_wr = (step_mode == PPC_MODE_DATA) && step_write;
  assign is_data_rd = (step_mode == PPC_MODE_DATA) && !step_write;
  // Any word but the agreed one leaves the security bit alone.
  assign is_secure_word = is_data_wr && (step_data == PPC_SECURITY_DATA);
  // The address wraps at the top of the space rather than saturating.
  assign addr_inc = st_r.addr + 32'h0000_0001;
  assign fifo_in_data = {st_r.addr, step_data};

  // ****************************************************************
  // Step decoder
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    fifo_in_valid = 1'b0;
    // The acknowledge falls one edge after the request is seen low.
    if (!step_req) begin
      st_nxt.ack = 1'b0;
    end
    if (erase_done) begin
      // Erase wipes the flash first; only then may security drop.
      st_nxt.secure = 1'b0;
      st_nxt.cmd = PPC_IDLE;
    end else if (new_step && st_r.secure) begin
      // Acknowledge so the programmer is not hung, but flag refusal.
      st_nxt.ack = 1'b1;
      st_nxt.err = 1'b1;
      st_nxt.rdata = PPC_DATA_RST;
    end else if (new_step) begin
      st_nxt.ack = 1'b1;
      st_nxt.err = 1'b0;
      // Only a read step leaves a word standing; every other answer,
      // refused ones included, shows zero so no stale mask leaks out.
      st_nxt.rdata = PPC_DATA_RST;
      if (is_cmd_wr) begin
        case (step_data)
          PPC_OP_READ_GPB: st_nxt.cmd = PPC_GPB_READ;
          PPC_OP_SET_SECURITY: st_nxt.cmd = PPC_SEC_DATA;
          PPC_OP_MEM_WRITE: st_nxt.cmd = PPC_ADDR_LO;
          default: begin
            st_nxt.cmd = PPC_IDLE;
            st_nxt.err = 1'b1;
          end
        endcase
      end else begin
        case (st_r.cmd)
          PPC_GPB_READ: begin
            // The mask is taken as the pins show it at this edge.
            if (is_data_rd) begin
              st_nxt.rdata = general_purpose_nonvolatile_bits;
            end else begin
              st_nxt.err = 1'b1;
            end
            st_nxt.cmd = PPC_IDLE;
          end
          PPC_SEC_DATA: begin
            // Any other word is refused, so a stray write cannot lock.
            if (is_secure_word) begin
              st_nxt.secure = 1'b1;
            end else begin
              st_nxt.err = 1'b1;
            end
            st_nxt.cmd = PPC_IDLE;
          end
          PPC_ADDR_LO: begin
            if (is_addr_lo_wr) begin
              st_nxt.addr[15:0] = step_data;
              st_nxt.cmd = PPC_ADDR_HI;
            end else begin
              st_nxt.err = 1'b1;
              st_nxt.cmd = PPC_IDLE;
            end
          end
          PPC_ADDR_HI: begin
            if (is_addr_hi_wr) begin
              st_nxt.addr[31:16] = step_data;
              st_nxt.cmd = PPC_WR_DATA;
            end else begin
              st_nxt.err = 1'b1;
              st_nxt.cmd = PPC_IDLE;
            end
          end
          PPC_WR_DATA: begin
            if (is_data_wr) begin
              // Hold the step unacknowledged while the buffer is full;
              // the address moves only when the word is really taken.
              if (fifo_in_ready) begin
                fifo_in_valid = 1'b1;
                st_nxt.addr = addr_inc;
              end else begin
                st_nxt.ack = 1'b0;
              end
            end else if (is_addr_lo_wr) begin
              // A new low half restarts the chain at a fresh address.
              st_nxt.addr[15:0] = step_data;
              st_nxt.cmd = PPC_ADDR_HI;
            end else begin
              st_nxt.err = 1'b1;
              st_nxt.cmd = PPC_IDLE;
            end
          end
          // Idle or an unknown state: only a command step is expected.
          default: begin
            st_nxt.err = 1'b1;
            st_nxt.cmd = PPC_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // A low enable freezes the decoder together with the buffer.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '{
        cmd: PPC_IDLE,
        addr: PPC_ADDR_RST,
        rdata: PPC_DATA_RST,
        ack: 1'b0,
        err: 1'b0,
        secure: 1'b0
      };
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Write buffer
  // ****************************************************************
  // Each entry pairs the word with the address it was taken at, so the
  // memory side always sees both change together.
  ppc_fifo #(
    .WIDTH(PPC_ADDR_W + PPC_DATA_W),
    .DEPTH(PPC_FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst(rst),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(mem_valid),
    .out_ready(mem_ready),
    .out_data(fifo_out)
  );
endmodule

// file: hw/ppc_pkg.sv
// Package of constants and types for the parallel programming command decoder.
// Functional notes
// - Read-bits command returns nonvolatile bit mask.
// - Set-security command then zero data write.
// - Security active disables port, refuses commands.
// - Only erase input clears security bit; rst also clears it here.
// - Security set rejects all port access.
// - Memory write: opcode, address low, high, data.
// - Chained data writes auto-increment the address.
package ppc_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned PPC_MODE_W = 4;
  localparam int unsigned PPC_DATA_W = 16;
  localparam int unsigned PPC_ADDR_W = 32;
  localparam int unsigned PPC_GPB_W = 16;
  localparam int unsigned PPC_FIFO_DEPTH = 4;
  // ****************************************************************
  // Mode codes and opcodes (arbitrary codes chosen for this block)
  // ****************************************************************
  localparam logic [3:0] PPC_MODE_COMMAND = 4'h1;
  localparam logic [3:0] PPC_MODE_ADDR_LOW = 4'h2;
  localparam logic [3:0] PPC_MODE_ADDR_HIGH = 4'h3;
  localparam logic [3:0] PPC_MODE_DATA = 4'h4;
  localparam logic [15:0] PPC_OP_READ_GPB = 16'h0001;
  localparam logic [15:0] PPC_OP_SET_SECURITY = 16'h0002;
  localparam logic [15:0] PPC_OP_MEM_WRITE = 16'h0003;
  localparam logic [15:0] PPC_SECURITY_DATA = 16'h0000;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] PPC_ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] PPC_DATA_RST = 16'h0000;

  typedef enum logic [2:0] {
    PPC_IDLE = 3'b000,
    PPC_GPB_READ = 3'b001,
    PPC_SEC_DATA = 3'b010,
    PPC_ADDR_LO = 3'b011,
    PPC_ADDR_HI = 3'b100,
    PPC_WR_DATA = 3'b101
  } ppc_cmd_t;
endpackage

// file: hw/ppc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module ppc_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ppc_fifo_st_t;
  ppc_fifo_st_t st_r, st_nxt;
  logic push, pop;

  assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data = st_r.mem[st_r.rp];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// file: tb/ppc_monitor.sv
// Checker of the decoder step port and memory stream.
`timescale 1ns/1ps
module ppc_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Step port
  input wire logic step_req,
  input wire logic [3:0] step_mode,
  input wire logic step_ack,
  input wire logic step_err,
  input wire logic [15:0] step_rdata,
  // Security and stream
  input wire logic erase_done,
  input wire logic security_bit,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire logic [31:0] mem_addr,
  input wire logic [15:0] mem_data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Data steps may wait for FIFO space, so they are left out here.
  a_ack_next_cycle: assert property (ce && step_req && !step_ack &&
    !erase_done && step_mode != 4'h4 |=> step_ack) else $error("ack late");
  a_ack_drop: assert property (ce && step_ack && !step_req |=>
    !step_ack) else $error("ack held");
  a_secure_refuse: assert property (ce && security_bit && step_req &&
    !step_ack && !erase_done |=> step_ack && step_err) else $error("ran");
  a_refused_zero: assert property (step_ack && step_err |->
    step_rdata == 16'h0000) else $error("refused data");
  a_erase_clears: assert property (ce && erase_done |=> !security_bit)
    else $error("not cleared");
  a_only_erase: assert property ($fell(security_bit) |->
    $past(erase_done)) else $error("cleared by step");
  a_word_hold: assert property (mem_valid && !mem_ready |=> mem_valid &&
    $stable(mem_addr) && $stable(mem_data)) else $error("word lost");
  a_addr_inc: assert property (ce && mem_valid && mem_ready ##1
    mem_valid |-> mem_addr == $past(mem_addr) + 32'h1)
    else $error("addr step");
endmodule
bind ppc_top ppc_monitor mon (
  .mclk(mclk),
  .rst(rst),
  .ce(ce),
  .step_req(step_req),
  .step_mode(step_mode),
  .step_ack(step_ack),
  .step_err(step_err),
  .step_rdata(step_rdata),
  .erase_done(erase_done),
  .security_bit(security_bit),
  .mem_valid(mem_valid),
  .mem_ready(mem_ready),
  .mem_addr(mem_addr),
  .mem_data(mem_data)
);

// file: tb/ppc_prog_model.sv
// Programmer model that drives the decoder step handshake.
`timescale 1ns/1ps
module ppc_prog_model (
  // Clock
  input wire logic mclk,
  // Step handshake
  output logic step_req,
  output logic step_write,
  output logic [ppc_pkg::PPC_MODE_W-1:0] step_mode,
  output logic [ppc_pkg::PPC_DATA_W-1:0] step_data,
  input wire logic step_ack,
  input wire logic step_err,
  input wire logic [ppc_pkg::PPC_DATA_W-1:0] step_rdata
);
  import ppc_pkg::*;
  logic err;
  logic [15:0] rd;
  initial begin
    step_req = 1'b0;
    step_write = 1'b0;
    step_mode = 4'h0;
    step_data = 16'h0000;
  end
  // Released mode and data lines show the inverse so stale values cannot pass.
  task automatic step(input logic [3:0] m, input logic [15:0] d,
                      input logic w);
    @(posedge mclk);
    step_req <= 1'b1;
    step_write <= w;
    step_mode <= m;
    step_data <= d;
    // A lost answer hangs here, and the bench watchdog fails the run.
    do @(posedge mclk); while (step_ack !== 1'b1);
    err = step_err;
    rd = step_rdata;
    step_req <= 1'b0;
    step_mode <= ~m;
    step_data <= ~d;
    do @(posedge mclk); while (step_ack !== 1'b0);
  endtask
endmodule

// file: tb/tb.sv
// Self-checking bench of the programming command decoder.
`timescale 1ns/1ps
module tb;
  import ppc_pkg::*;
  logic mclk, rst, ce, erase_done, mem_ready, step_req, step_write;
  logic step_ack, step_err, security_bit, mem_valid;
  logic [3:0] step_mode;
  logic [15:0] gpb, step_data, step_rdata, mem_data;
  logic [31:0] mem_addr;
  logic [47:0] got[$];
  int bad_count, checks;
  initial begin mclk = 0; forever #10 mclk = ~mclk; end
  ppc_top DUT (.mclk(mclk), .rst(rst), .ce(ce), .step_req(step_req),
    .step_write(step_write), .step_mode(step_mode), .step_data(step_data),
    .step_ack(step_ack), .step_rdata(step_rdata), .step_err(step_err),
    .general_purpose_nonvolatile_bits(gpb), .erase_done(erase_done),
    .security_bit(security_bit), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_data(mem_data));
  ppc_prog_model prog (.mclk(mclk), .step_req(step_req),
    .step_write(step_write), .step_mode(step_mode), .step_data(step_data),
    .step_ack(step_ack), .step_err(step_err), .step_rdata(step_rdata));
  always @(posedge mclk) if (mem_valid && mem_ready && ce)
    got.push_back({mem_addr, mem_data});
  task chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_read_bits;
    gpb <= 16'ha5c3;
    prog.step(PPC_MODE_COMMAND, PPC_OP_READ_GPB, 1'b1);
    prog.step(PPC_MODE_DATA, 16'h0000, 1'b0);
    chk({prog.err, prog.rd}, 17'h0a5c3);
    $display("read bits done");
  endtask
  task t_mem_write;
    int i;
    mem_ready <= 1'b0;
    prog.step(PPC_MODE_COMMAND, PPC_OP_MEM_WRITE, 1'b1);
    prog.step(PPC_MODE_ADDR_LOW, 16'hfffe, 1'b1);
    prog.step(PPC_MODE_ADDR_HIGH, 16'h0012, 1'b1);
    for (i = 0; i < 4; i++) prog.step(PPC_MODE_DATA, 16'h1000 + i[15:0], 1'b1);
    #1 chk({mem_valid, mem_addr}, {1'b1, 32'h0012fffe});
    fork
      prog.step(PPC_MODE_DATA, 16'h1004, 1'b1);
      begin
        repeat (6) @(posedge mclk);
        #1 chk(step_ack, 0);
        @(posedge mclk);
        ce <= 1'b0;
        mem_ready <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk(got.size(), 0);
        chk(step_ack, 0);
        @(posedge mclk);
        ce <= 1'b1;
      end
    join
    repeat (4) @(posedge mclk);
    chk(got.size(), 5);
    for (i = 0; i < 5; i++) begin
      chk(got[i][47:16], 32'h0012fffe + i);
      chk(got[i][15:0], 16'h1000 + i);
    end
    $display("memory write done");
  endtask
  task t_security;
    int i;
    prog.step(PPC_MODE_COMMAND, 16'h0007, 1'b1);
    chk({prog.err, prog.rd}, 17'h10000);
    prog.step(PPC_MODE_COMMAND, PPC_OP_SET_SECURITY, 1'b1);
    prog.step(PPC_MODE_DATA, 16'h0001, 1'b1);
    chk({prog.err, security_bit}, 2'b10);
    prog.step(PPC_MODE_COMMAND, PPC_OP_SET_SECURITY, 1'b1);
    prog.step(PPC_MODE_DATA, PPC_SECURITY_DATA, 1'b1);
    chk({prog.err, security_bit}, 2'b01);
    for (i = 1; i < 4; i++) begin
      prog.step(PPC_MODE_COMMAND, i[15:0], 1'b1);
      chk({prog.err, prog.rd, security_bit}, 18'h20001);
    end
    erase_done <= 1'b1;
    @(posedge mclk);
    erase_done <= 1'b0;
    @(posedge mclk);
    #1 chk(security_bit, 0);
    t_read_bits;
    $display("security done");
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    erase_done = 1'b0;
    mem_ready = 1'b0;
    gpb = 16'h0000;
    bad_count = 0;
    checks = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_read_bits;
    t_mem_write;
    t_security;
    stop_test;
  end
  // The tests need well under two hundred cycles; this allows many times that.
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
endmodule
